// [common/hpb_cfg.svh]
// Purpose: constants for the host processor bus port
// Assumes: one 200 MHz ref_clk, synchronous active-high reset
// Notes: widths, mode codes, reset values and byte-enable bit offsets live here, types live in hpb_pkg
// Contract
// - accept only with both selects active
// - host may tie selects permanently active
// - config-time select decode built off-device
// - internal decode routed out and back
// - host sets up before strobe; read high
// - separate bus: write data next edge
// - separate bus: acknowledge low one cycle
// - burst inhibit low with acknowledge
// - separate bus: read data at acknowledge
// - forward user interrupt, held until withdrawn
// - mux: address latched while latch enable
// - mux: direction high means write
// - mux: host setup, strobe at edge
// - mux: write data one cycle later
// - mux: ready low exactly one cycle
// - mux: read data at ready low
// - mux: byte enables give address bits
// - wait states until user logic done
`ifndef HPB_CFG_SVH
`define HPB_CFG_SVH
`define HPB_ADDR_W 5
`define HPB_DATA_W 8
`define HPB_MODE_SEP 1'b0
`define HPB_MODE_MUX 1'b1
`define HPB_RST_DATA 8'h00
`define HPB_RST_ADDR 5'h00
`define HPB_BE0_BIT 0
`define HPB_BE1_BIT 1
`endif

// [common/hpb_if.sv]
// Purpose: pin-level link between host and port
// Assumes: data bus is two-way; level resolved here
// Notes: both ends run on ref_clk
`timescale 1ns/1ps
interface hpb_if;
	logic select_low_active_n;
	logic select_high_active;
	logic port_strobe_in_n;
	logic port_direction_in;
	logic port_addr_latch_in;
	logic [4:0] addr;
	logic byte_enable_zero;
	logic byte_enable_one;
	logic [7:0] host_data_out;
	logic host_data_oe;
	logic [7:0] dev_data_out;
	logic dev_data_oe;
	logic port_ack_out_n;
	logic port_burst_inhibit_out_n;
	logic port_irq_out_n;
	wire [7:0] data_bus;
	// wire level from the two enables; device wins if both drive
	assign data_bus = dev_data_oe ? dev_data_out : (host_data_oe ? host_data_out : 8'hff);
	modport device (
		input select_low_active_n, select_high_active, port_strobe_in_n,
		input port_direction_in, port_addr_latch_in, addr, byte_enable_zero,
		input byte_enable_one, data_bus,
		output dev_data_out, dev_data_oe, port_ack_out_n,
		output port_burst_inhibit_out_n, port_irq_out_n
	);
	modport host (
		output select_low_active_n, select_high_active, port_strobe_in_n,
		output port_direction_in, port_addr_latch_in, addr, byte_enable_zero,
		output byte_enable_one, host_data_out, host_data_oe,
		input data_bus, port_ack_out_n, port_burst_inhibit_out_n, port_irq_out_n
	);
endinterface

// [common/hpb_pkg.sv]
// Purpose: shared types for the host processor bus port
// Assumes: included constants from hpb_cfg.svh
// Notes: device and host states kept apart
package hpb_pkg;
	typedef enum logic [1:0] {
		HPB_DEV_IDLE = 2'b00,
		HPB_DEV_DATA = 2'b01,
		HPB_DEV_WAIT = 2'b10,
		HPB_DEV_ACK = 2'b11
	} hpb_dev_state_t;
	typedef enum logic [1:0] {
		HPB_HST_IDLE = 2'b00,
		HPB_HST_STRB = 2'b01,
		HPB_HST_WAIT = 2'b10
	} hpb_hst_state_t;
endpackage

// [design/hpb_device.sv]
// Purpose: device end of the host processor bus port
// Assumes: host pins are synchronous to ref_clk and checked one edge later
// Notes: user logic sees start/done handshake; latency follows user_done
`timescale 1ns/1ps
`include "hpb_cfg.svh"
module hpb_device
	import hpb_pkg::*;
#(
	parameter int ADDR_W = `HPB_ADDR_W,
	parameter int DATA_W = `HPB_DATA_W
) (
	input wire logic ref_clk, // port clock
	input wire logic rst, // synchronous reset
	input wire logic mode_mux, // 1 = multiplexed personality
	hpb_if.device bus, // host pins
	output logic [ADDR_W-1:0] user_addr, // latched address
	output logic user_read, // 1 = host reads
	output logic user_start, // transfer in progress
	output logic [DATA_W-1:0] user_wdata, // write data
	input wire logic user_done, // user logic finished
	input wire logic [DATA_W-1:0] user_rdata, // read data
	input wire logic user_irq_n, // user interrupt request
	output logic irq_pending // pollable interrupt status
);
	// widths are fixed by the pin interface; any other value cannot be served
	if (ADDR_W != `HPB_ADDR_W || DATA_W != `HPB_DATA_W) begin : g_width_check
		$error("hpb_device: only 5-bit address and 8-bit data are supported");
	end

	// a request counts only with both selects active; a stray strobe is ignored
	function automatic logic sel_take(
		input logic strobe_n, // transfer strobe, low active
		input logic sel_n, // low-active select
		input logic sel // high-active select
	);
		return !strobe_n && !sel_n && sel;
	endfunction

	// multiplexed mode: upper bits from the falling-edge latch, low two from byte enables
	function automatic logic [ADDR_W-1:0] mux_addr(
		input logic [ADDR_W-1:0] latched, // address caught on the falling edge
		input logic be_one, // byte enable one, address bit 1
		input logic be_zero // byte enable zero, address bit 0
	);
		return {latched[ADDR_W-1:2], be_one, be_zero};
	endfunction

	// the direction pin has opposite sense in the two personalities
	function automatic logic dir_is_read(
		input logic mux, // 1 = multiplexed personality
		input logic dir // direction pin as sampled
	);
		return mux ? !dir : dir;
	endfunction

	// transfer engine state
	hpb_dev_state_t state_ff, nxt_state;
	// address and direction held for the user side through the transfer
	logic [ADDR_W-1:0] addr_ff, nxt_addr;
	logic read_ff, nxt_read;
	logic start_ff, nxt_start;
	// write data in, read data out
	logic [DATA_W-1:0] wdata_ff, nxt_wdata;
	logic [DATA_W-1:0] rdata_ff, nxt_rdata;
	// pin drivers: data enable and acknowledge
	logic oe_ff, nxt_oe;
	logic ack_n_ff, nxt_ack_n;
	// falling-edge address latch
	logic [ADDR_W-1:0] ale_addr_ff, nxt_ale_addr;
	// interrupt synchroniser, pin and status copies
	logic irq_s1_ff, irq_s2_ff, irq_n_ff, irq_pend_ff;
	logic nxt_irq_s1, nxt_irq_s2, nxt_irq_n, nxt_irq_pend;

	// falling-edge address capture while latch enable is high
	always_comb begin
		nxt_ale_addr = ale_addr_ff;
		if (bus.port_addr_latch_in) begin
			nxt_ale_addr = bus.data_bus[ADDR_W-1:0];
		end
	end

	// the only falling-edge flops; the rising-edge engine reads them half a cycle later
	always_ff @(negedge ref_clk) begin
		if (rst) begin
			ale_addr_ff <= `HPB_RST_ADDR;
		end else begin
			ale_addr_ff <= nxt_ale_addr;
		end
	end

	// transfer engine; selects checked at the strobe edge only
	always_comb begin
		nxt_state = state_ff;
		nxt_addr = addr_ff;
		nxt_read = read_ff;
		nxt_start = start_ff;
		nxt_wdata = wdata_ff;
		nxt_rdata = rdata_ff;
		nxt_oe = 1'b0;
		nxt_ack_n = 1'b1;
		// defaults: hold state, acknowledge high, data pins released
		unique case (state_ff)
			HPB_DEV_IDLE: begin
				if (sel_take(bus.port_strobe_in_n, bus.select_low_active_n,
						bus.select_high_active)) begin
					nxt_state = HPB_DEV_DATA;
					nxt_read = dir_is_read(mode_mux, bus.port_direction_in);
					if (mode_mux) begin
						nxt_addr = mux_addr(ale_addr_ff, bus.byte_enable_one,
							bus.byte_enable_zero);
					end else begin
						nxt_addr = bus.addr;
					end
				end
			end
			HPB_DEV_DATA: begin
				// no strobe is looked at here: one transfer at a time
				// write data next edge
				if (!read_ff) begin
					nxt_wdata = bus.data_bus;
				end
				nxt_start = 1'b1;
				nxt_state = HPB_DEV_WAIT;
			end
			HPB_DEV_WAIT: begin
				// hold host until done
				// read data is taken with user_done so it stands through the ack cycle
				if (user_done) begin
					nxt_start = 1'b0;
					nxt_rdata = user_rdata;
					nxt_oe = read_ff;
					nxt_ack_n = 1'b0;
					nxt_state = HPB_DEV_ACK;
				end
			end
			HPB_DEV_ACK: begin
				// back to idle; the host cannot strobe before this cycle ends
				nxt_state = HPB_DEV_IDLE;
			end
		endcase
	end

	// engine registers; the acknowledge, data and user outputs below are taken straight from these
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_ff <= HPB_DEV_IDLE;
			addr_ff <= `HPB_RST_ADDR;
			read_ff <= 1'b0;
			start_ff <= 1'b0;
			wdata_ff <= `HPB_RST_DATA;
			rdata_ff <= `HPB_RST_DATA;
			oe_ff <= 1'b0;
			ack_n_ff <= 1'b1;
		end else begin
			state_ff <= nxt_state;
			addr_ff <= nxt_addr;
			read_ff <= nxt_read;
			start_ff <= nxt_start;
			wdata_ff <= nxt_wdata;
			rdata_ff <= nxt_rdata;
			oe_ff <= nxt_oe;
			ack_n_ff <= nxt_ack_n;
		end
	end

	// user interrupt is asynchronous, so two flops before use
	// pin and status copy both leave the second stage together
	always_comb begin
		nxt_irq_s1 = user_irq_n;
		nxt_irq_s2 = irq_s1_ff;
		nxt_irq_n = irq_s2_ff;
		nxt_irq_pend = !irq_s2_ff;
	end

	// request held as long as user logic holds it; no clear from the host side
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			irq_s1_ff <= 1'b1;
			irq_s2_ff <= 1'b1;
			irq_n_ff <= 1'b1;
			irq_pend_ff <= 1'b0;
		end else begin
			irq_s1_ff <= nxt_irq_s1;
			irq_s2_ff <= nxt_irq_s2;
			irq_n_ff <= nxt_irq_n;
			irq_pend_ff <= nxt_irq_pend;
		end
	end

	// pins below come straight from flops; no logic between flop and pin
	// one-cycle acknowledge
	assign bus.port_ack_out_n = ack_n_ff;
	assign bus.port_burst_inhibit_out_n = ack_n_ff;
	assign bus.dev_data_out = rdata_ff;
	assign bus.dev_data_oe = oe_ff;
	assign bus.port_irq_out_n = irq_n_ff;
	assign irq_pending = irq_pend_ff;
	// user side: these stand from user_start until the acknowledge
	assign user_addr = addr_ff;
	assign user_read = read_ff;
	assign user_start = start_ff;
	assign user_wdata = wdata_ff;
endmodule

// [design/hpb_host.sv]
// Purpose: host end driving the port pins
// Assumes: the host board ties or decodes selects outside the device
// Notes: one single-byte transfer per command, no bursts
`timescale 1ns/1ps
`include "hpb_cfg.svh"
module hpb_host
	import hpb_pkg::*;
(
	input wire logic ref_clk, // bus clock
	input wire logic rst, // synchronous reset
	input wire logic mode_mux, // 1 = multiplexed personality
	input wire logic cmd_valid, // start a transfer
	input wire logic cmd_read, // 1 = read
	input wire logic [4:0] cmd_addr, // target address
	input wire logic [7:0] cmd_wdata, // write data
	output logic cmd_ready, // idle, may take a command
	output logic done, // transfer finished pulse
	output logic [7:0] rdata, // read data
	output logic irq, // device interrupt seen
	hpb_if.host bus // port pins
);
	hpb_hst_state_t state_ff, nxt_state;
	logic read_ff, nxt_read, done_ff, nxt_done, irq_ff;
	logic [4:0] addr_ff, nxt_addr;
	logic [7:0] wdata_ff, nxt_wdata, rdata_ff, nxt_rdata;
	// registered pin levels
	logic strobe_n_ff, nxt_strobe_n, dir_ff, nxt_dir, latch_ff, nxt_latch;
	logic oe_ff, nxt_oe, ready_ff, nxt_ready;
	logic [7:0] dout_ff, nxt_dout;

	always_comb begin
		nxt_state = state_ff;
		nxt_read = read_ff;
		nxt_addr = addr_ff;
		nxt_wdata = wdata_ff;
		nxt_rdata = rdata_ff;
		nxt_done = 1'b0;
		unique case (state_ff)
			HPB_HST_IDLE: begin
				if (cmd_valid) begin
					nxt_read = cmd_read;
					nxt_addr = cmd_addr;
					nxt_wdata = cmd_wdata;
					nxt_state = HPB_HST_STRB;
				end
			end
			HPB_HST_STRB: nxt_state = HPB_HST_WAIT;
			HPB_HST_WAIT: begin
				if (!bus.port_ack_out_n) begin
					if (read_ff) begin
						nxt_rdata = bus.data_bus;
					end
					nxt_done = 1'b1;
					nxt_state = HPB_HST_IDLE;
				end
			end
			default: nxt_state = HPB_HST_IDLE;
		endcase
		// pin levels for the next cycle follow the next state
		nxt_strobe_n = (nxt_state != HPB_HST_STRB);
		// multiplexed direction is high for write
		nxt_dir = mode_mux ? !nxt_read : nxt_read;
		// multiplexed: latch enable and address on the low data lines with the strobe
		nxt_latch = mode_mux && (nxt_state == HPB_HST_STRB);
		nxt_dout = nxt_latch ? {3'h0, nxt_addr} : nxt_wdata;
		nxt_oe = nxt_latch || (nxt_state != HPB_HST_IDLE && !nxt_read);
		nxt_ready = (nxt_state == HPB_HST_IDLE);
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_ff <= HPB_HST_IDLE;
			read_ff <= 1'b0;
			addr_ff <= `HPB_RST_ADDR;
			wdata_ff <= `HPB_RST_DATA;
			rdata_ff <= `HPB_RST_DATA;
			done_ff <= 1'b0;
			irq_ff <= 1'b0;
			strobe_n_ff <= 1'b1;
			dir_ff <= 1'b0;
			latch_ff <= 1'b0;
			dout_ff <= `HPB_RST_DATA;
			oe_ff <= 1'b0;
			ready_ff <= 1'b1;
		end else begin
			state_ff <= nxt_state;
			read_ff <= nxt_read;
			addr_ff <= nxt_addr;
			wdata_ff <= nxt_wdata;
			rdata_ff <= nxt_rdata;
			done_ff <= nxt_done;
			irq_ff <= !bus.port_irq_out_n;
			strobe_n_ff <= nxt_strobe_n;
			dir_ff <= nxt_dir;
			latch_ff <= nxt_latch;
			dout_ff <= nxt_dout;
			oe_ff <= nxt_oe;
			ready_ff <= nxt_ready;
		end
	end

	// selects tied active; decode lives off-device
	assign bus.select_low_active_n = 1'b0;
	assign bus.select_high_active = 1'b1;
	// every pin leaves a flop, so the device sees settled levels at its edge
	assign bus.port_strobe_in_n = strobe_n_ff;
	assign bus.port_direction_in = dir_ff;
	assign bus.port_addr_latch_in = latch_ff;
	assign bus.addr = addr_ff;
	assign bus.byte_enable_zero = addr_ff[`HPB_BE0_BIT];
	assign bus.byte_enable_one = addr_ff[`HPB_BE1_BIT];
	// multiplexed: address on the low data lines during the strobe, then write data
	assign bus.host_data_out = dout_ff;
	assign bus.host_data_oe = oe_ff;
	assign cmd_ready = ready_ff;
	assign done = done_ff;
	assign rdata = rdata_ff;
	assign irq = irq_ff;
endmodule

// [dv/host_processor_bus_port_tb.sv]
// Purpose: host and port ends joined, random byte traffic
// Assumes: the bench answers the user side
// Notes: both personalities, then interrupt
`timescale 1ns/1ps
module host_processor_bus_port_tb;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic mode_mux = 1'b0;
	logic cmd_valid = 1'b0;
	logic cmd_read = 1'b0;
	logic [4:0] cmd_addr = 5'h00;
	logic [7:0] cmd_wdata = 8'h00;
	logic user_done = 1'b0;
	logic [7:0] user_rdata = 8'h00;
	logic user_irq_n = 1'b1;
	logic cmd_ready, done, irq, user_read, user_start, irq_pending;
	logic [7:0] rdata, user_wdata, v;
	logic [4:0] user_addr;
	logic [31:0] seed = 32'h1f;
	logic [31:0] r;
	logic [13:0] req_q[$]; // read, address, write data
	logic [8:0] rd_q[$]; // read, read data
	logic [13:0] e;
	logic [8:0] n;
	int fail_count = 0;
	int checks_done = 0;
	hpb_if bus();
	hpb_host i_hpb_host(.ref_clk, .rst, .mode_mux, .cmd_valid, .cmd_read, .cmd_addr,
		.cmd_wdata, .cmd_ready, .done, .rdata, .irq, .bus);
	hpb_device i_hpb_device(.ref_clk, .rst, .mode_mux, .bus, .user_addr, .user_read,
		.user_start, .user_wdata, .user_done, .user_rdata, .user_irq_n, .irq_pending);
	hpb_checker i_hpb_checker(.ref_clk, .rst, .select_low_active_n(bus.select_low_active_n),
		.select_high_active(bus.select_high_active), .port_strobe_in_n(bus.port_strobe_in_n),
		.port_ack_out_n(bus.port_ack_out_n), .dev_data_oe(bus.dev_data_oe),
		.port_burst_inhibit_out_n(bus.port_burst_inhibit_out_n),
		.port_irq_out_n(bus.port_irq_out_n));
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic chk(input string s, input logic [7:0] x, input logic [7:0] y);
		checks_done++;
		if (x !== y) begin
			$display("MISMATCH %s exp %h got %h", s, x, y);
			fail_count++;
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// valid held until the host takes it, then wait for done
	task automatic xfer(input logic rd, input logic [4:0] a, input logic [7:0] d);
		req_q.push_back({rd, a, d});
		cmd_valid <= 1'b1;
		cmd_read <= rd;
		cmd_addr <= a;
		cmd_wdata <= d;
		do @(posedge ref_clk); while (cmd_ready !== 1'b1);
		cmd_valid <= 1'b0;
		do @(posedge ref_clk); while (done !== 1'b1);
	endtask
	initial forever #2.5 ref_clk = ~ref_clk;
	// user side: check the request, answer after 0..3 stall cycles
	initial forever begin
		@(posedge ref_clk);
		if (user_start === 1'b1) begin
			e = req_q.pop_front();
			v = 8'(rnd());
			chk("addr", {3'h0, e[12:8]}, {3'h0, user_addr});
			chk("dir", {7'h00, e[13]}, {7'h00, user_read});
			if (!e[13]) chk("wdata", e[7:0], user_wdata);
			rd_q.push_back({e[13], v});
			repeat (v[1:0]) @(posedge ref_clk);
			user_rdata <= v;
			user_done <= 1'b1;
			@(posedge ref_clk);
			user_done <= 1'b0;
		end
	end
	// read data is compared in the done cycle
	always @(posedge ref_clk) begin
		if (done === 1'b1) begin
			n = rd_q.pop_front();
			if (n[8]) chk("rdata", n[7:0], rdata);
		end
	end
	// a hang counts as a failure
	initial begin
		repeat (4000) @(posedge ref_clk);
		fail_count++;
		close_out();
	end
	// main sequence; first two addresses are the extremes
	initial begin
		repeat (12) @(posedge ref_clk);
		rst <= 1'b0;
		for (int m = 0; m < 2; m++) begin
			mode_mux <= m[0];
			for (int i = 0; i < 12; i++) begin
				r = rnd();
				xfer(r[0], (i < 2) ? {5{i[0]}} : r[12:8], r[23:16]);
			end
			$display("test mode %0d finished", m);
		end
		user_irq_n <= 1'b0;
		repeat (6) @(posedge ref_clk);
		chk("irq", 8'h03, {6'h00, irq, irq_pending});
		xfer(1'b1, 5'h15, 8'h00);
		chk("irq pin", 8'h00, {7'h00, bus.port_irq_out_n});
		user_irq_n <= 1'b1;
		repeat (6) @(posedge ref_clk);
		chk("irq off", 8'h04, {5'h00, bus.port_irq_out_n, irq, irq_pending});
		$display("test irq finished");
		close_out();
	end
endmodule

// [dv/hpb_checker.sv]
// Purpose: protocol checks on the port pins
// Assumes: one clock, rst sync high
// Notes: latency bound covers the bench user delay
`timescale 1ns/1ps
module hpb_checker (
	input wire logic ref_clk, // clock
	input wire logic rst, // reset
	input wire logic select_low_active_n, // select
	input wire logic select_high_active, // select
	input wire logic port_strobe_in_n, // strobe
	input wire logic port_ack_out_n, // ack
	input wire logic port_burst_inhibit_out_n, // burst inhibit
	input wire logic dev_data_oe, // device drives data
	input wire logic port_irq_out_n // interrupt
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	logic take;
	logic busy_ff;
	assign take = !port_strobe_in_n && !select_low_active_n && select_high_active;
	// open transfer, so a stray ack shows up
	always_ff @(posedge ref_clk) begin
		if (rst || !port_ack_out_n) busy_ff <= 1'b0;
		else if (take) busy_ff <= 1'b1;
	end
	property p_one; !port_ack_out_n |=> port_ack_out_n [*3]; endproperty
	a_one: assert property (p_one) else $error("ack not single");
	property p_bi; port_burst_inhibit_out_n == port_ack_out_n; endproperty
	a_bi: assert property (p_bi) else $error("bi apart from ack");
	property p_oe; dev_data_oe |-> !port_ack_out_n; endproperty
	a_oe: assert property (p_oe) else $error("drive outside ack");
	property p_oe_end; $rose(port_ack_out_n) |-> !dev_data_oe; endproperty
	a_oe_end: assert property (p_oe_end) else $error("drive held");
	property p_wait; take |=> port_ack_out_n [*2]; endproperty
	a_wait: assert property (p_wait) else $error("ack too early");
	property p_bound; take |-> ##[3:40] !port_ack_out_n; endproperty
	a_bound: assert property (p_bound) else $error("ack missing");
	property p_only; $fell(port_ack_out_n) |-> busy_ff; endproperty
	a_only: assert property (p_only) else $error("ack unasked");
	property p_strb; !port_strobe_in_n |-> port_ack_out_n; endproperty
	a_strb: assert property (p_strb) else $error("ack at strobe");
	c_take: cover property (take);
	c_read: cover property (dev_data_oe);
	c_ack: cover property (!port_ack_out_n);
	c_irq: cover property (!port_irq_out_n);
endmodule
